// file: timer_defs.svh
/*
 * Register offsets, field positions, reset values and divider counts of
 * the periodic timer.  Assumes a 32-bit APB bus with one byte-wide
 * register in the low lane of each aligned word.
 */
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ****************************************************************
// Register byte addresses.
// ****************************************************************
`define OFF_CTRL0         8'h00
`define OFF_CTRL1         8'h04
`define OFF_CAPCLR        8'h08
`define OFF_COUNT_LO      8'h0C
`define OFF_COUNT_HI      8'h10
`define OFF_CMPA_LO       8'h14
`define OFF_CMPA_HI       8'h18
`define OFF_CMPB_LO       8'h1C
`define OFF_CMPB_HI       8'h20
`define OFF_PERIOD_LO     8'h24
`define OFF_PERIOD_HI     8'h28
`define OFF_INSRC         8'h2C

// ****************************************************************
// Field positions.
// ****************************************************************
`define C0_PAUSE          7
`define C0_CKSEL_HI       6
`define C0_CKSEL_LO       4
`define C0_ON             3
`define C1_MODE_HI        7
`define C1_MODE_LO        6
`define C1_PF_HI          5
`define C1_PF_LO          4
`define C1_OC             3
`define C1_INV            2
`define C1_CAPTS          1
`define C1_CCLR           0
`define C2_TCLR_HI        2
`define C2_TCLR_LO        1
`define C2_VLF            0
`define INSRC_LINE        6

// ****************************************************************
// Reset values and counter limits.
// ****************************************************************
`define RST_BYTE          8'h00
`define RST_VALUE         10'h000
`define COUNT_MAX         10'h3FF

// ****************************************************************
// Divider counts.
// ****************************************************************
`define DIV_SYS_LAST      2'h3
`define DIV_H16_LAST      4'hF
`define DIV_H64_LAST      6'h3F

`endif

// file: timer_types_pkg.sv
/*
 * Types shared by the periodic timer modules.
 * Assumes nothing of its surroundings.
 */
package timer_types_pkg;

  typedef logic [9:0] count_t;
  typedef logic [2:0] clk_sel_t;

  typedef enum {
    MODE_COMPARE,
    MODE_CAPTURE,
    MODE_PWM,
    MODE_TIMER
  } mode_e;

endpackage

// file: timer_clock_source.sv
/*
 * Counter clock source selection for the periodic timer: produces a
 * one-cycle tick enable from the system clock, the high and sub clock
 * tick inputs or the edges of the external clock pin.  Assumes all inputs
 * are synchronous to pclk and that the tick inputs are one-cycle pulses.
 */
`timescale 1ns/1ps
`include "timer_defs.svh"

module timer_clock_source (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      run,
  input  wire timer_types_pkg::clk_sel_t clock_select,
  input  wire logic                      high_clk_tick,
  input  wire logic                      sub_clk_tick,
  input  wire logic                      ext_clock_pin,
  output logic                           timer_tick
);
  import timer_types_pkg::*;

  logic [1:0] sys_div;
  logic [5:0] high_div;
  logic       ext_q;
  logic       next_tick;

  // ****************************************************************
  // Dividers.
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_div  <= 2'h0;
      high_div <= 6'h00;
      ext_q    <= 1'b0;
    end else begin
      sys_div <= sys_div + 2'h1;
      if (high_clk_tick) begin
        high_div <= high_div + 6'h01;
      end
      ext_q <= ext_clock_pin;
    end
  end

  // ****************************************************************
  // Source selection.
  // ****************************************************************
  // clock source decode.
  always_comb begin
    case (clock_select)
      3'h0:    next_tick = (sys_div == `DIV_SYS_LAST);
      3'h1:    next_tick = 1'b1;
      3'h2:    next_tick = high_clk_tick &&
                           (high_div[3:0] == `DIV_H16_LAST);
      3'h3:    next_tick = high_clk_tick && (high_div == `DIV_H64_LAST);
      3'h4:    next_tick = sub_clk_tick;
      3'h5:    next_tick = sub_clk_tick;
      3'h6:    next_tick = ext_clock_pin && !ext_q;
      3'h7:    next_tick = !ext_clock_pin && ext_q;
      default: next_tick = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_tick <= 1'b0;
    end else begin
      timer_tick <= run && next_tick;
    end
  end

endmodule // timer_clock_source

// file: periodic_timer_module.sv
/*
 * Ten-bit periodic timer with comparators A and P, compare output, PWM,
 * single pulse, capture and timer modes, reached over APB.
 * Assumes APB master signals synchronous to pclk, pin inputs synchronous
 * to pclk, and one-cycle tick pulses for the high and sub clocks.
 */
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "timer_defs.svh"

// Contract
// - Ten-bit up counter on selected clock.
// - Comparators A and P match all bits.
// - Counter clear raises interrupt event.
// - On rise clears count; fall stops, holds.
// - Pause holds count, resumes on release.
// - Clock select field decode.
// - Output to initial level on on-rise, except timer, capture modes.
// - Mode select field decode.
// - Compare mode A match drives pin.
// - No change if request equals initial.
// - PWM mode pin function decode.
// - Units 1,2 capture edge select.
// - Unit 0 capture into compare A.
// - Unit 0 edge split into A, B.
// - Output level control per mode.
// - Output invert except timer, capture modes.
// - Capture source select.
// - Clear select picks A or P/overflow.
// - Clear select ignored in PWM, capture.
// - Compare B, capture clear unit 0 only.
// - Count readable; value registers byte pairs.
// - Capture edges may clear counter.
// - Latch edge flag records capture edge.
module periodic_timer_module #(
  parameter bit UNIT_ZERO = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        high_clk_tick,
  input  wire logic        sub_clk_tick,
  input  wire logic        ext_clock_pin,
  input  wire logic        capture_input_pin,
  input  wire logic        line_comparator_out,
  output logic             timer_output_pin,
  output logic             match_a_event,
  output logic             match_p_event
);
  import timer_types_pkg::*;

  logic                  counter_pause;
  clk_sel_t              clock_select;
  logic                  counter_on;
  logic [1:0]            mode_select;
  logic [1:0]            pin_function;
  logic                  output_level_control;
  logic                  output_invert;
  logic                  capture_source_select;
  logic                  clear_select;
  logic [1:0]            capture_clear_select;
  logic                  latch_edge_flag;
  logic                  input_source_select;
  count_t                compare_a;
  count_t                compare_b;
  count_t                period_value;
  count_t                count;
  logic                  on_q;
  logic                  trig_q;
  logic                  out_level;
  logic                  timer_tick;
  mode_e                 mode;
  logic                  wr;
  logic                  on_rise;
  logic                  on_fall;
  logic                  a_hit;
  logic                  p_hit;
  logic                  clr_tick;
  logic                  single;
  logic                  trig;
  logic                  trig_rise;
  logic                  trig_fall;
  logic                  cap_fire;
  logic                  cap_clr;
  logic                  hw_off;
  logic [8:0]            rd;

  // ****************************************************************
  // Decoding helpers.
  // ****************************************************************
  // mode decode.
  function automatic mode_e decode_mode(input logic [1:0] m);
    case (m)
      2'h0:    decode_mode = MODE_COMPARE;
      2'h1:    decode_mode = MODE_CAPTURE;
      2'h2:    decode_mode = MODE_PWM;
      default: decode_mode = MODE_TIMER;
    endcase
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    hit = (a == o);
  endfunction

  assign mode = decode_mode(mode_select);
  assign wr   = psel && penable && pready && pwrite && pstrb[0];

  // ****************************************************************
  // APB handshake and read data.
  // ****************************************************************
  // register read map.
  always_comb begin
    rd = {1'b1, 8'h00};
    if (hit(paddr, `OFF_CTRL0)) begin
      rd[7:0] = {counter_pause, clock_select, counter_on, 3'h0};
    end else if (hit(paddr, `OFF_CTRL1)) begin
      rd[7:0] = {mode_select, pin_function, output_level_control,
                 output_invert, capture_source_select, clear_select};
    end else if (hit(paddr, `OFF_COUNT_LO)) begin
      rd[7:0] = count[7:0];
    end else if (hit(paddr, `OFF_COUNT_HI)) begin
      rd[7:0] = {6'h00, count[9:8]};
    end else if (hit(paddr, `OFF_CMPA_LO)) begin
      rd[7:0] = compare_a[7:0];
    end else if (hit(paddr, `OFF_CMPA_HI)) begin
      rd[7:0] = {6'h00, compare_a[9:8]};
    end else if (hit(paddr, `OFF_PERIOD_LO)) begin
      rd[7:0] = period_value[7:0];
    end else if (hit(paddr, `OFF_PERIOD_HI)) begin
      rd[7:0] = {6'h00, period_value[9:8]};
    end else if (UNIT_ZERO && hit(paddr, `OFF_CAPCLR)) begin
      rd[7:0] = {5'h00, capture_clear_select, latch_edge_flag};
    end else if (UNIT_ZERO && hit(paddr, `OFF_CMPB_LO)) begin
      rd[7:0] = compare_b[7:0];
    end else if (UNIT_ZERO && hit(paddr, `OFF_CMPB_HI)) begin
      rd[7:0] = {6'h00, compare_b[9:8]};
    end else if (UNIT_ZERO && hit(paddr, `OFF_INSRC)) begin
      rd[7:0] = {1'b0, input_source_select, 6'h00};
    end else begin
      rd[8] = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !rd[8];
      if (psel && penable && !pready && !pwrite) begin
        prdata <= {24'h00_0000, rd[7:0]};
      end
    end
  end

  // ****************************************************************
  // Control registers.
  // ****************************************************************
  // hardware stop at the end of a single pulse.
  assign hw_off = single && a_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_pause <= 1'b0;
      clock_select  <= 3'h0;
      counter_on    <= 1'b0;
    end else if (wr && hit(paddr, `OFF_CTRL0)) begin
      counter_pause <= pwdata[`C0_PAUSE];
      clock_select  <= pwdata[`C0_CKSEL_HI:`C0_CKSEL_LO];
      counter_on    <= pwdata[`C0_ON];
    end else if (hw_off) begin
      counter_on <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_select           <= 2'h0;
      pin_function          <= 2'h0;
      output_level_control  <= 1'b0;
      output_invert         <= 1'b0;
      capture_source_select <= 1'b0;
      clear_select          <= 1'b0;
    end else if (wr && hit(paddr, `OFF_CTRL1)) begin
      mode_select           <= pwdata[`C1_MODE_HI:`C1_MODE_LO];
      pin_function          <= pwdata[`C1_PF_HI:`C1_PF_LO];
      output_level_control  <= pwdata[`C1_OC];
      output_invert         <= pwdata[`C1_INV];
      capture_source_select <= pwdata[`C1_CAPTS];
      clear_select          <= pwdata[`C1_CCLR];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_clear_select <= 2'h0;
      input_source_select  <= 1'b0;
    end else if (UNIT_ZERO && wr && hit(paddr, `OFF_CAPCLR)) begin
      capture_clear_select <= pwdata[`C2_TCLR_HI:`C2_TCLR_LO];
    end else if (UNIT_ZERO && wr && hit(paddr, `OFF_INSRC)) begin
      input_source_select <= pwdata[`INSRC_LINE];
    end
  end

  // ****************************************************************
  // Compare values and capture latching.
  // ****************************************************************
  // capture trigger source.
  assign trig = capture_source_select ? ext_clock_pin :
                (UNIT_ZERO && input_source_select) ? line_comparator_out :
                capture_input_pin;
  assign trig_rise = trig && !trig_q;
  assign trig_fall = !trig && trig_q;

  always_comb begin
    case (pin_function)
      2'h0:    cap_fire = trig_rise;
      2'h1:    cap_fire = trig_fall;
      2'h2:    cap_fire = trig_rise || trig_fall;
      default: cap_fire = 1'b0;
    endcase
    cap_fire = cap_fire && counter_on && (mode == MODE_CAPTURE);
  end

  always_comb begin
    case (capture_clear_select)
      2'h1:    cap_clr = trig_rise;
      2'h2:    cap_clr = trig_fall;
      2'h3:    cap_clr = trig_rise || trig_fall;
      default: cap_clr = 1'b0;
    endcase
    cap_clr = cap_clr && UNIT_ZERO && counter_on &&
              (mode == MODE_CAPTURE);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= trig;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_a       <= `RST_VALUE;
      compare_b       <= `RST_VALUE;
      latch_edge_flag <= 1'b0;
    end else if (cap_fire) begin
      latch_edge_flag <= trig_rise;
      // split rising into B, falling into A.
      if (UNIT_ZERO && capture_clear_select != 2'h0 && trig_rise) begin
        compare_b <= count;
      end else begin
        compare_a <= count;
      end
    end else if (wr && hit(paddr, `OFF_CMPA_LO)) begin
      compare_a[7:0] <= pwdata[7:0];
    end else if (wr && hit(paddr, `OFF_CMPA_HI)) begin
      compare_a[9:8] <= pwdata[1:0];
    end else if (UNIT_ZERO && wr && hit(paddr, `OFF_CMPB_LO)) begin
      compare_b[7:0] <= pwdata[7:0];
    end else if (UNIT_ZERO && wr && hit(paddr, `OFF_CMPB_HI)) begin
      compare_b[9:8] <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_value <= `RST_VALUE;
    end else if (wr && hit(paddr, `OFF_PERIOD_LO)) begin
      period_value[7:0] <= pwdata[7:0];
    end else if (wr && hit(paddr, `OFF_PERIOD_HI)) begin
      period_value[9:8] <= pwdata[1:0];
    end
  end

  // ****************************************************************
  // Counter.
  // ****************************************************************
  // pause stops the counter clock.
  timer_clock_source u_clock_source (
    .pclk          (pclk),
    .presetn       (presetn),
    .run           (counter_on && !counter_pause),
    .clock_select  (clock_select),
    .high_clk_tick (high_clk_tick),
    .sub_clk_tick  (sub_clk_tick),
    .ext_clock_pin (ext_clock_pin),
    .timer_tick    (timer_tick)
  );

  assign on_rise = counter_on && !on_q;
  assign on_fall = !counter_on && on_q;
  assign single  = (mode == MODE_PWM) && (pin_function == 2'h3);

  // comparator A, ignored at zero in compare and timer modes.
  // checked only on a counter tick.
  assign a_hit = timer_tick && counter_on && !counter_pause &&
                 (count == compare_a) && (mode != MODE_CAPTURE) &&
                 !((mode == MODE_COMPARE || mode == MODE_TIMER) &&
                   compare_a == `RST_VALUE);

  // period zero means overflow; no P event with A clearing.
  assign p_hit = timer_tick && counter_on && !counter_pause && !single &&
                 ((period_value == `RST_VALUE) ? (count == `COUNT_MAX) :
                  (count == period_value)) &&
                 !((mode == MODE_COMPARE || mode == MODE_TIMER) &&
                   clear_select);

  // clear select only in compare and timer modes.
  assign clr_tick = ((mode == MODE_COMPARE || mode == MODE_TIMER) &&
                     clear_select) ? a_hit : p_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_q <= 1'b0;
    end else begin
      on_q <= counter_on;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= `RST_VALUE;
    end else if (on_rise || cap_clr) begin
      count <= `RST_VALUE;
    end else if (timer_tick && counter_on && !counter_pause && !hw_off) begin
      count <= clr_tick ? `RST_VALUE : count + 10'h001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_a_event <= 1'b0;
      match_p_event <= 1'b0;
    end else begin
      match_a_event <= a_hit || cap_fire;
      match_p_event <= p_hit;
    end
  end

  // ****************************************************************
  // Output waveform.
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_level <= 1'b0;
    end else if (on_rise && mode != MODE_TIMER && mode != MODE_CAPTURE) begin
      out_level <= output_level_control;
    end else if (mode == MODE_COMPARE && a_hit) begin
      // same level gives no visible change.
      case (pin_function)
        2'h1:    out_level <= 1'b0;
        2'h2:    out_level <= 1'b1;
        2'h3:    out_level <= !out_level;
        default: out_level <= out_level;
      endcase
    end else if (single) begin
      if (a_hit || on_fall) begin
        out_level <= !output_level_control;
      end
    end else if (mode == MODE_PWM) begin
      case (pin_function)
        2'h0:    out_level <= !output_level_control;
        2'h1:    out_level <= output_level_control;
        default: out_level <= (count < compare_a) ? output_level_control :
                              !output_level_control;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_output_pin <= 1'b0;
    end else if (mode == MODE_TIMER || mode == MODE_CAPTURE) begin
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_pin <= out_level ^ output_invert;
    end
  end

endmodule // periodic_timer_module

// file: timer_pins_model.sv
/*
 * Model of the pins around the periodic timer: clock ticks, the external
 * clock pin and the capture pins.  Assumes the bench sets cap_level.
 */
`timescale 1ns/1ps

module timer_pins_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic cap_level,
  output logic      high_clk_tick,
  output logic      sub_clk_tick,
  output logic      ext_clock_pin,
  output logic      capture_input_pin,
  output logic      line_comparator_out
);
  logic [3:0] div;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 4'h0;
    end else begin
      div <= div + 4'h1;
    end
  end

  assign high_clk_tick = div[0];
  assign sub_clk_tick = (div == 4'hF);
  assign ext_clock_pin = div[2];
  assign capture_input_pin = cap_level;
  assign line_comparator_out = ~cap_level;
endmodule // timer_pins_model

// file: timer_checker.sv
/*
 * Assertions on the ports of the periodic timer.
 * Assumes it is bound to every periodic_timer_module instance.
 */
`timescale 1ns/1ps

module timer_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        match_a_event,
  input wire logic        match_p_event
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  ready_wait_a: assert property ((psel && !penable) |-> ##2 pready)
    else $error("no answer two cycles after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  ready_access_a: assert property (pready |-> psel && $past(penable))
    else $error("ready outside access phase");
  error_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  rdata_upper_a: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  rdata_hold_a: assert property (!pready |-> $stable(prdata))
    else $error("read data changed outside access");
  match_a_pulse_a: assert property (match_a_event |=> !match_a_event)
    else $error("match a longer than one cycle");
  match_p_pulse_a: assert property (match_p_event |=> !match_p_event)
    else $error("match p longer than one cycle");
endmodule // timer_checker

bind periodic_timer_module timer_checker i_timer_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .match_a_event(match_a_event), .match_p_event(match_p_event));

// file: test_periodic_timer_module.sv
/*
 * Self-checking bench for the periodic timer over APB.
 * Assumes the pin model and the bound checker are compiled alongside.
 */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH %0t value differs", $time); end end

module test_periodic_timer_module;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00, q;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, e, cap = 0, hi, sub, ext, cp, lc, outp, ma, mp;
  int bad_count = 0, cmp_count = 0;

  timer_pins_model i_timer_pins_model (.pclk(pclk), .presetn(presetn),
    .cap_level(cap), .high_clk_tick(hi), .sub_clk_tick(sub),
    .ext_clock_pin(ext), .capture_input_pin(cp), .line_comparator_out(lc));
  periodic_timer_module i_periodic_timer_module (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .high_clk_tick(hi),
    .sub_clk_tick(sub), .ext_clock_pin(ext), .capture_input_pin(cp),
    .line_comparator_out(lc), .timer_output_pin(outp),
    .match_a_event(ma), .match_p_event(mp));

  always #12.5 pclk = ~pclk;

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin bad_count++; report_and_stop(); end
    q = prdata[7:0]; e = pslverr; psel <= 0; penable <= 0;
  endtask

  task automatic wait_ev(input logic pick);
    int n;
    n = 0;
    do begin
      @(posedge pclk); #1; n++;
    end while ((pick ? mp : ma) !== 1'b1 && n < 2000);
    if (n >= 2000) begin bad_count++; report_and_stop(); end
  endtask

  initial begin
    logic [7:0] c1;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    // ************ Reset values and decode ************
    for (int a = 0; a <= 8'h28; a += 4) begin
      apb(0, a[7:0], 8'h00); `CHK(q, 8'h00)
    end
    apb(0, 8'h30, 8'h00); `CHK(e, 1'b1)
    $display("test reset done");
    // ************ Every clock source counts ************
    apb(1, 8'h04, 8'hC0);
    for (int cs = 0; cs < 8; cs++) begin
      apb(1, 8'h00, {1'b0, cs[2:0], 4'h0});
      apb(1, 8'h00, {1'b0, cs[2:0], 4'h8});
      repeat (150) @(posedge pclk);
      apb(0, 8'h0C, 8'h00); `CHK(q != 8'h00, 1'b1)
    end
    $display("test clocks done");
    // ************ Compare output, stop, pause ************
    apb(1, 8'h00, 8'h10);
    apb(1, 8'h24, 8'h05); apb(1, 8'h14, 8'h03); apb(1, 8'h04, 8'h18);
    apb(1, 8'h00, 8'h18);
    repeat (2) @(posedge pclk); #1; `CHK(outp, 1'b1)
    wait_ev(0); @(posedge pclk); #1; `CHK(outp, 1'b0)
    wait_ev(1); `CHK(ma, 1'b0)
    apb(1, 8'h00, 8'h10); apb(0, 8'h0C, 8'h00); c1 = q;
    repeat (10) @(posedge pclk);
    apb(0, 8'h0C, 8'h00); `CHK(q, c1)
    apb(1, 8'h00, 8'h18); apb(1, 8'h00, 8'h98); apb(0, 8'h0C, 8'h00); c1 = q;
    apb(0, 8'h0C, 8'h00); `CHK(q, c1)
    $display("test compare done");
    // ************ PWM with invert, single pulse ************
    apb(1, 8'h00, 8'h10); apb(1, 8'h04, 8'hAC);
    apb(1, 8'h00, 8'h18); wait_ev(1); `CHK(outp, 1'b1)
    repeat (2) @(posedge pclk); #1; `CHK(outp, 1'b0)
    apb(1, 8'h00, 8'h10); apb(1, 8'h04, 8'hB8);
    apb(1, 8'h00, 8'h18); repeat (2) @(posedge pclk); #1;
    `CHK(outp, 1'b1)
    wait_ev(0); @(posedge pclk); #1; `CHK(outp, 1'b0)
    apb(0, 8'h00, 8'h00); `CHK(q, 8'h10)
    apb(0, 8'h0C, 8'h00); `CHK(q, 8'h03)
    $display("test pwm done");
    // ************ Capture on rising edge ************
    apb(1, 8'h00, 8'h10); apb(1, 8'h24, 8'h00); apb(1, 8'h04, 8'h40);
    apb(1, 8'h2C, 8'h00); apb(1, 8'h14, 8'h00); apb(1, 8'h00, 8'h18);
    repeat (20) @(posedge pclk);
    cap <= 1;
    wait_ev(0); `CHK(outp, 1'b0)
    apb(0, 8'h14, 8'h00); `CHK(q != 8'h00, 1'b1)
    $display("test capture done");
    report_and_stop();
  end

  initial begin
    #2000000;
    bad_count++;
    report_and_stop();
  end
endmodule // test_periodic_timer_module
